// *** hdl/slx_crossbar.sv ***
`timescale 1ns/1ps
// Operation
// R1 - four separate writable 3-bit selectors feed logical lanes 4 to 7
// R2 - selector value n routes physical input n to that lane
// R3 - lanes 6 and 7 share one register, lane 6 low; reset 6 and 7
// R4 - lanes 4 and 5 share one register, lane 4 low; reset 4 and 5
// R5 - read-only 8-bit full flags, bit n for physical input n
// R6 - full flags read zero after reset; writes ignored
// R7 - read-only 8-bit empty flags per input, zero after reset
// R8 - selector change affects whole following words only, never mixed
module slx_crossbar
  import slx_pkg::*;
#(
  parameter int WORD_W = 32,
  parameter int NUM_PHYS = 8
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire slx_pkg::slx_cfg_req_t cfg_req,
  output logic [7:0] cfg_rdata,
  input wire logic [NUM_PHYS-1:0][WORD_W-1:0] phys_word,
  input wire logic [NUM_PHYS-1:0] phys_valid,
  input wire logic [NUM_PHYS-1:0] buffer_full,
  input wire logic [NUM_PHYS-1:0] buffer_empty,
  output logic [3:0][WORD_W-1:0] lane_word,
  output logic [3:0] lane_valid
);
  import slx_pkg::*;

  // ==========================================
  // configuration state
  logic [2:0] sel4, sel5, sel6, sel7;
  logic [2:0] next_sel4, next_sel5, next_sel6, next_sel7;
  logic [7:0] full_q, empty_q, full_s1, empty_s1;
  logic [7:0] next_rdata;

  function automatic logic hit(input logic [9:0] a, input logic [9:0] off);
    hit = (a == off);
  endfunction : hit

  always_comb begin
    next_sel4 = sel4;
    next_sel5 = sel5;
    next_sel6 = sel6;
    next_sel7 = sel7;
    if (cfg_req.wr) begin
      if (hit(cfg_req.addr, OFF_ROUTE_45)) begin
        next_sel4 = cfg_req.wdata[LO_SEL_LSB +: SEL_W]; // R1 R4
        next_sel5 = cfg_req.wdata[HI_SEL_LSB +: SEL_W]; // R4
      end else if (hit(cfg_req.addr, OFF_ROUTE_67)) begin
        next_sel6 = cfg_req.wdata[LO_SEL_LSB +: SEL_W]; // R1 R3
        next_sel7 = cfg_req.wdata[HI_SEL_LSB +: SEL_W]; // R3
      end
      // writes to status offsets fall through untouched
    end
  end

  // reserved bits [7:6] read zero; unmapped reads zero
  always_comb begin
    next_rdata = 8'h00;
    if (cfg_req.rd) begin
      if (hit(cfg_req.addr, OFF_ROUTE_45)) begin
        next_rdata = {2'h0, sel5, sel4};
      end else if (hit(cfg_req.addr, OFF_ROUTE_67)) begin
        next_rdata = {2'h0, sel7, sel6};
      end else if (hit(cfg_req.addr, OFF_FULL)) begin
        next_rdata = full_q; // R5 R6
      end else if (hit(cfg_req.addr, OFF_EMPTY)) begin
        next_rdata = empty_q; // R7
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      sel4 <= RST_SEL4; // R4
      sel5 <= RST_SEL5;
      sel6 <= RST_SEL6; // R3
      sel7 <= RST_SEL7;
      full_s1 <= RST_FLAGS;
      full_q <= RST_FLAGS; // R6
      empty_s1 <= RST_FLAGS;
      empty_q <= RST_FLAGS; // R7
      cfg_rdata <= 8'h00;
    end else begin
      sel4 <= next_sel4;
      sel5 <= next_sel5;
      sel6 <= next_sel6;
      sel7 <= next_sel7;
      // flags come from buffers on other clocks, so two stages
      full_s1 <= buffer_full;
      full_q <= full_s1; // R5
      empty_s1 <= buffer_empty;
      empty_q <= empty_s1;
      cfg_rdata <= next_rdata;
    end
  end

  // ==========================================
  // lane muxes
  logic [3:0][2:0] sel_vec;
  assign sel_vec = {sel7, sel6, sel5, sel4};

  generate
    for (genvar g = 0; g < 4; g++) begin : g_lane
      slx_lane_mux #(.WORD_W(WORD_W), .NUM_PHYS(NUM_PHYS)) u_mux (
        .clock(clock),
        .rst_b(rst_b),
        .phys_word(phys_word),
        .phys_valid(phys_valid),
        .source_select(sel_vec[g]),
        .lane_word(lane_word[g]),
        .lane_valid(lane_valid[g])
      );
    end
  endgenerate

  // ==========================================
  // checks
  property p_sel_write;
    @(posedge clock) disable iff (!rst_b)
      cfg_req.wr && cfg_req.addr == OFF_ROUTE_45 |=> sel4 == $past(cfg_req.wdata[2:0]);
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("lane 4 selector not written"); // R1

  property p_route;
    @(posedge clock) disable iff (!rst_b)
      1 |=> lane_word[0] == $past(phys_word[sel4]);
  endproperty
  a_route: assert property (p_route) else $error("lane 4 word from wrong input"); // R2

  property p_pack67;
    @(posedge clock) disable iff (!rst_b)
      cfg_req.rd && cfg_req.addr == OFF_ROUTE_67 |=> cfg_rdata == {2'h0, $past(sel7), $past(sel6)};
  endproperty
  a_pack67: assert property (p_pack67) else $error("lane 6/7 readback wrong"); // R3

  property p_pack45;
    @(posedge clock) disable iff (!rst_b)
      cfg_req.rd && cfg_req.addr == OFF_ROUTE_45 |=> cfg_rdata == {2'h0, $past(sel5), $past(sel4)};
  endproperty
  a_pack45: assert property (p_pack45) else $error("lane 4/5 readback wrong"); // R4

  property p_full;
    @(posedge clock) disable iff (!rst_b)
      cfg_req.rd && cfg_req.addr == OFF_FULL |=> cfg_rdata == $past(full_q);
  endproperty
  a_full: assert property (p_full) else $error("full flags misread"); // R5

  property p_full_ro;
    @(posedge clock) disable iff (!rst_b)
      cfg_req.wr && cfg_req.addr == OFF_FULL |=> $stable(sel4) && $stable(sel5) && $stable(sel6) && $stable(sel7);
  endproperty
  a_full_ro: assert property (p_full_ro) else $error("status write changed state"); // R6

  property p_empty;
    @(posedge clock) disable iff (!rst_b)
      1 |-> ##2 empty_q == $past(buffer_empty, 2);
  endproperty
  a_empty: assert property (p_empty) else $error("empty flags lag wrong"); // R7

  property p_whole;
    @(posedge clock) disable iff (!rst_b)
      $changed(sel7) |=> lane_word[3] == $past(phys_word[sel7]);
  endproperty
  a_whole: assert property (p_whole) else $error("lane 7 mixed word"); // R8

  property p_sel5_write;
    @(posedge clock) disable iff (!rst_b)
      cfg_req.wr && cfg_req.addr == OFF_ROUTE_45 |=> sel5 == $past(cfg_req.wdata[5:3]);
  endproperty
  a_sel5_write: assert property (p_sel5_write) else $error("lane 5 selector not written"); // R4

  property p_sel6_write;
    @(posedge clock) disable iff (!rst_b)
      cfg_req.wr && cfg_req.addr == OFF_ROUTE_67 |=> sel6 == $past(cfg_req.wdata[2:0]);
  endproperty
  a_sel6_write: assert property (p_sel6_write) else $error("lane 6 selector not written"); // R3

  property p_sel7_write;
    @(posedge clock) disable iff (!rst_b)
      cfg_req.wr && cfg_req.addr == OFF_ROUTE_67 |=> sel7 == $past(cfg_req.wdata[5:3]);
  endproperty
  a_sel7_write: assert property (p_sel7_write) else $error("lane 7 selector not written"); // R3

  property p_route5;
    @(posedge clock) disable iff (!rst_b)
      1 |=> lane_word[1] == $past(phys_word[sel5]);
  endproperty
  a_route5: assert property (p_route5) else $error("lane 5 word from wrong input"); // R2

  property p_route6;
    @(posedge clock) disable iff (!rst_b)
      1 |=> lane_word[2] == $past(phys_word[sel6]);
  endproperty
  a_route6: assert property (p_route6) else $error("lane 6 word from wrong input"); // R2

  property p_route7;
    @(posedge clock) disable iff (!rst_b)
      1 |=> lane_word[3] == $past(phys_word[sel7]);
  endproperty
  a_route7: assert property (p_route7) else $error("lane 7 word from wrong input"); // R2

  property p_valid_pick;
    @(posedge clock) disable iff (!rst_b)
      1 |=> lane_valid == $past({phys_valid[sel7], phys_valid[sel6], phys_valid[sel5], phys_valid[sel4]});
  endproperty
  a_valid_pick: assert property (p_valid_pick) else $error("lane valid from wrong input"); // R8

  property p_empty_read;
    @(posedge clock) disable iff (!rst_b)
      cfg_req.rd && cfg_req.addr == OFF_EMPTY |=> cfg_rdata == $past(empty_q);
  endproperty
  a_empty_read: assert property (p_empty_read) else $error("empty flags misread"); // R7

  property p_full_sync;
    @(posedge clock) disable iff (!rst_b)
      1 |-> ##2 full_q == $past(buffer_full, 2);
  endproperty
  a_full_sync: assert property (p_full_sync) else $error("full flags lag wrong"); // R5

  c_route45: cover property (@(posedge clock) cfg_req.wr && cfg_req.addr == OFF_ROUTE_45);
  c_route67: cover property (@(posedge clock) cfg_req.wr && cfg_req.addr == OFF_ROUTE_67);
  c_full: cover property (@(posedge clock) full_q != 8'h00);
  c_empty: cover property (@(posedge clock) empty_q != 8'h00);
  c_lane_idle: cover property (@(posedge clock) lane_valid != 4'hF);
endmodule : slx_crossbar

// *** common/slx_pkg.sv ***
package slx_pkg;
  // ==========================================
  // geometry
  localparam int NUM_PHYS = 8;
  localparam int SEL_W = 3;
  localparam int WORD_W = 32;
  localparam int ADDR_W = 10;
  localparam int REG_W = 8;
  // ==========================================
  // register offsets
  localparam logic [9:0] OFF_ROUTE_45 = 10'h30A;
  localparam logic [9:0] OFF_ROUTE_67 = 10'h30B;
  localparam logic [9:0] OFF_FULL = 10'h30C;
  localparam logic [9:0] OFF_EMPTY = 10'h30D;
  // ==========================================
  // field positions
  localparam int LO_SEL_LSB = 0;
  localparam int HI_SEL_LSB = 3;
  // ==========================================
  // reset values
  localparam logic [2:0] RST_SEL4 = 3'h4;
  localparam logic [2:0] RST_SEL5 = 3'h5;
  localparam logic [2:0] RST_SEL6 = 3'h6;
  localparam logic [2:0] RST_SEL7 = 3'h7;
  localparam logic [7:0] RST_FLAGS = 8'h00;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [9:0] addr;
    logic [7:0] wdata;
  } slx_cfg_req_t;
endpackage : slx_pkg

// *** hdl/slx_lane_mux.sv ***
`timescale 1ns/1ps
// ==========================================
// one logical lane: registered word pick
module slx_lane_mux #(
  parameter int WORD_W = 32,
  parameter int NUM_PHYS = 8
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [NUM_PHYS-1:0][WORD_W-1:0] phys_word,
  input wire logic [NUM_PHYS-1:0] phys_valid,
  input wire logic [2:0] source_select,
  output logic [WORD_W-1:0] lane_word,
  output logic lane_valid
);
  logic [WORD_W-1:0] next_lane_word;
  logic next_lane_valid;

  // whole word from one input per cycle, selector sampled with the word
  always_comb begin
    next_lane_word = phys_word[source_select]; // R2 R8
    next_lane_valid = phys_valid[source_select];
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      lane_word <= '0;
      lane_valid <= 1'h0;
    end else begin
      lane_word <= next_lane_word;
      lane_valid <= next_lane_valid;
    end
  end
endmodule : slx_lane_mux

// *** testbench/slx_tx_model.sv ***
`timescale 1ns/1ps
// ==========
// transmitter side: input n carries a word of byte n
module slx_tx_model (
  input wire logic clock,
  output logic [7:0][31:0] phys_word,
  output logic [7:0] phys_valid
);
  initial begin
    phys_word = '0;
    phys_valid = 8'h00;
  end
  // distinct bytes per input so any mixing of inputs shows
  always @(negedge clock) begin
    for (int n = 0; n < 8; n++) begin
      phys_word[n] <= {4{8'(n)}};
    end
    // input 7 stays idle so a wrong valid pick shows
    phys_valid <= 8'h7F;
  end
endmodule : slx_tx_model

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import slx_pkg::*;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  slx_cfg_req_t cfg_req = '0;
  logic [7:0] cfg_rdata;
  logic [7:0][31:0] phys_word;
  logic [7:0] phys_valid;
  logic [7:0] buffer_full = 8'h00;
  logic [7:0] buffer_empty = 8'h00;
  logic [3:0][31:0] lane_word;
  logic [3:0] lane_valid;
  int n_fail = 0;
  int checked = 0;
  initial forever #25 clock = ~clock;
  slx_tx_model i_slx_tx_model (.clock(clock), .phys_word(phys_word), .phys_valid(phys_valid));
  slx_crossbar i_slx_crossbar (.clock(clock), .rst_b(rst_b), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
    .phys_word(phys_word), .phys_valid(phys_valid), .buffer_full(buffer_full),
    .buffer_empty(buffer_empty), .lane_word(lane_word), .lane_valid(lane_valid));
  // ==========
  // tasks
  task conclude;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude
  task cmp8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: reg got %h expected %h", $time, got, exp);
    end
  endtask : cmp8
  task cmp_lane(input int i, input logic [2:0] sel);
    checked++;
    if (lane_word[i] !== {4{5'h00, sel}} || lane_valid[i] !== (sel != 3'h7)) begin
      n_fail++;
      $display("wrong value at %0t: lane %0d got %h from %0d", $time, i + 4, lane_word[i], sel);
    end
  endtask : cmp_lane
  task wr(input logic [9:0] addr, input logic [7:0] data);
    @(negedge clock);
    cfg_req = '{1'b1, 1'b0, addr, data};
    @(negedge clock);
    cfg_req = '0;
  endtask : wr
  // strobe goes low at the negedge after it is taken, read data is there then
  task rd(input logic [9:0] addr, input logic [7:0] exp);
    @(negedge clock);
    cfg_req = '{1'b0, 1'b1, addr, 8'h00};
    @(negedge clock);
    cfg_req = '0;
    cmp8(cfg_rdata, exp);
  endtask : rd
  // ==========
  // tests
  initial begin
    repeat (10) @(negedge clock);
    rst_b = 1'b1;
    rd(10'h30A, 8'h2C);
    rd(10'h30B, 8'h3E);
    rd(10'h30C, 8'h00);
    rd(10'h30D, 8'h00);
    for (int i = 0; i < 4; i++) cmp_lane(i, 3'(i + 4));
    // every code on every lane, reserved bits written high
    for (int n = 0; n < 8; n++) begin
      wr(10'h30A, {2'b11, 3'(7 - n), 3'(n)});
      wr(10'h30B, {2'b11, 3'(n), 3'(7 - n)});
      rd(10'h30A, {2'b00, 3'(7 - n), 3'(n)});
      rd(10'h30B, {2'b00, 3'(n), 3'(7 - n)});
      cmp_lane(0, 3'(n));
      cmp_lane(1, 3'(7 - n));
      cmp_lane(2, 3'(7 - n));
      cmp_lane(3, 3'(n));
    end
    buffer_full = 8'hA5;
    buffer_empty = 8'h5A;
    repeat (4) @(negedge clock);
    rd(10'h30C, 8'hA5);
    wr(10'h30C, 8'hFF);
    rd(10'h30C, 8'hA5);
    rd(10'h30D, 8'h5A);
    rd(10'h3FF, 8'h00);
    conclude();
  end
  // whole run is well under 200 cycles
  initial begin
    #50000;
    n_fail++;
    conclude();
  end
endmodule : testbench
